// file: test/cpu_program_control_regs_tb.sv
// self-checking bench for the program-control register block
`timescale 1ns/10ps
`default_nettype none
module cpu_program_control_regs_tb;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, branch_from_reg_i;
  logic [2:0] reg_addr_i, instr_len_i;
  logic [7:0] reg_wdata_i, result_i, mem_rdata_i, irq_req_i, irq_mask_i, irq_low_prio_i;
  logic [15:0] branch_imm_i, branch_reg_i;
  logic [5:0] table_index_field_i;
  logic [1:0] bank_num_i;
  logic [11:0] op;
  logic [7:0] mem [0:127];
  wire advance_i, branch_i, table_call_instr_i, status_push_instr_i, status_pop_instr_i;
  wire break_return_instr_i, interrupt_return_instr_i, mask_all_instr_i, unmask_all_instr_i;
  wire bank_choose_instr_i, result_valid_i, irq_ack_i, irq_accept_o, mem_rd_o, mem_wr_o, busy_o;
  wire [7:0] reg_rdata_o, mem_wdata_o, status_word_o, irq_grant_o;
  wire [15:0] mem_addr_o, instruction_pointer_o, stack_top_pointer_o;
  wire [1:0] bank_select_o;
  int errors = 0;
  int n_checks = 0;
  int i;
  // command word of single-bit strobes, advance in the top bit down to acknowledge
  assign {advance_i, branch_i, table_call_instr_i, status_push_instr_i, status_pop_instr_i,
    break_return_instr_i, interrupt_return_instr_i, mask_all_instr_i, unmask_all_instr_i,
    bank_choose_instr_i, result_valid_i, irq_ack_i} = op;
  pcr_core_regs dut (.*);
  // byte memory, read data one cycle after the address
  always @(posedge clk_i) begin
    mem_rdata_i <= mem[mem_addr_o[6:0]];
    if (mem_wr_o) mem[mem_addr_o[6:0]] <= mem_wdata_o;
  end
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, e);
  endtask
  // one-cycle command, then a bounded wait for the sequencer to idle
  task cmd(input logic [11:0] c);
    @(posedge clk_i);
    op <= c;
    @(posedge clk_i);
    op <= 12'h000;
    #1;
    repeat (4) if (busy_o !== 1'b0) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // watchdog, 2500 cycles, ample for the fewer than a hundred cycles of tests
  initial begin
    #20000;
    errors++;
    conclude;
  end
  initial begin
    rst_n_i = 1'b0;
    op = 12'h000;
    {reg_wr_i, reg_rd_i, branch_from_reg_i, reg_addr_i, instr_len_i, reg_wdata_i} = '0;
    {result_i, irq_req_i, irq_mask_i, irq_low_prio_i, branch_imm_i, branch_reg_i} = '0;
    {table_index_field_i, bank_num_i} = '0;
    mem[0] = 8'h34;
    mem[1] = 8'h12;
    mem[126] = 8'hCD;
    mem[127] = 8'hAB;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("ip", instruction_pointer_o, 16'h1234);
    chk("sw", status_word_o, 8'h02);
    rd(3'h2, 8'h02);
    wr(3'h3, 8'h30);
    wr(3'h0, 8'h55);
    rd(3'h0, 8'h34);
    rd(3'h1, 8'h12);
    rd(3'h6, 8'h00);
    rd(3'h5, 8'h08);
    rd(3'h4, 8'h00);
    rd(3'h3, 8'h30);
    instr_len_i <= 3'h3;
    cmd(12'h800);
    chk("ip", instruction_pointer_o, 16'h1237);
    branch_imm_i <= 16'h2000;
    branch_reg_i <= 16'hBEEF;
    cmd(12'hC00);
    chk("ip", instruction_pointer_o, 16'h2000);
    branch_from_reg_i <= 1'b1;
    cmd(12'h400);
    chk("ip", instruction_pointer_o, 16'hBEEF);
    cmd(12'h008);
    chk("sw", status_word_o, 8'h82);
    // source 2 masked, source 3 low priority but allowed by the flag
    irq_req_i <= 8'h0C;
    irq_mask_i <= 8'h04;
    irq_low_prio_i <= 8'h08;
    #1;
    chk("grant", irq_grant_o, 8'h08);
    irq_mask_i <= 8'h0C;
    #1;
    chk("accept", irq_accept_o, 1'b0);
    irq_mask_i <= 8'h00;
    cmd(12'h010);
    chk("accept", irq_accept_o, 1'b0);
    for (i = 0; i < 4; i++) begin
      bank_num_i <= i[1:0];
      cmd(12'h004);
      chk("bank", bank_select_o, i[1:0]);
    end
    result_i <= 8'h00;
    cmd(12'h002);
    chk("zero", status_word_o[6], 1'b1);
    result_i <= 8'h80;
    cmd(12'h002);
    chk("zero", status_word_o[6], 1'b0);
    // save with enable set, disturb, restore by pop, break and interrupt return
    for (i = 0; i < 3; i++) begin
      cmd(12'h008);
      cmd(i == 2 ? 12'h001 : 12'h100);
      cmd(12'h010);
      chk("stack_ptr", stack_top_pointer_o, 16'h002F);
      chk("stack", mem[7'h2F], 8'hAA);
      cmd(12'h080 >> i);
      chk("sw", status_word_o, 8'hAA);
      chk("stack_ptr", stack_top_pointer_o, 16'h0030);
    end
    table_index_field_i <= 6'h3F;
    cmd(12'h200);
    chk("ip", instruction_pointer_o, 16'hABCD);
    conclude;
  end
endmodule // cpu_program_control_regs_tb
`default_nettype wire

// file: test/pcr_core_regs_sva.sv
// assertion checker for the program-control register block
`timescale 1ns/10ps
`default_nettype none
module pcr_core_regs_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic status_push_instr_i,
  input wire logic status_pop_instr_i,
  input wire logic break_return_instr_i,
  input wire logic interrupt_return_instr_i,
  input wire logic mask_all_instr_i,
  input wire logic unmask_all_instr_i,
  input wire logic irq_ack_i,
  input wire logic bank_choose_instr_i,
  input wire logic [1:0] bank_num_i,
  input wire logic result_valid_i,
  input wire logic [7:0] result_i,
  input wire logic table_call_instr_i,
  input wire logic [5:0] table_index_field_i,
  input wire logic [7:0] irq_req_i,
  input wire logic [7:0] irq_mask_i,
  input wire logic [7:0] irq_low_prio_i,
  input wire logic irq_accept_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [7:0] status_word_o,
  input wire logic [15:0] stack_top_pointer_o,
  input wire logic [1:0] bank_select_o,
  input wire logic busy_o
);
  // one clock domain, so one clocking and one disable for all
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // stack traffic, pre-decrement on push, post-increment on pop
  property p_push;
    status_push_instr_i && !busy_o |-> mem_wr_o && mem_addr_o == stack_top_pointer_o - 16'h1
      && mem_wdata_o == status_word_o;
  endproperty
  a_push: assert property (p_push) else $error("push cycle wrong");
  property p_pop;
    status_pop_instr_i && !busy_o && !status_push_instr_i && !irq_ack_i |=> ##1
      stack_top_pointer_o == $past(stack_top_pointer_o, 2) + 16'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  // enable flag: clear wins over set
  property p_di;
    (mask_all_instr_i || irq_ack_i) && !busy_o |=> !status_word_o[7];
  endproperty
  a_di: assert property (p_di) else $error("enable not cleared");
  property p_ei;
    unmask_all_instr_i && !mask_all_instr_i && !irq_ack_i && !busy_o |=> status_word_o[7];
  endproperty
  a_ei: assert property (p_ei) else $error("enable not set");
  property p_gate;
    irq_accept_o == (status_word_o[7] && |(irq_req_i & ~irq_mask_i
      & (~irq_low_prio_i | {8{status_word_o[1]}})));
  endproperty
  a_gate: assert property (p_gate) else $error("accept wrong");
  property p_zero;
    result_valid_i && !busy_o |=> status_word_o[6] == ($past(result_i) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_bank;
    bank_choose_instr_i && !busy_o |=> bank_select_o == $past(bank_num_i);
  endproperty
  a_bank: assert property (p_bank) else $error("bank wrong");
  // table fetch reads the entry pair, low byte first
  property p_tbl;
    table_call_instr_i && !busy_o && !status_push_instr_i && !status_pop_instr_i
      && !irq_ack_i && !break_return_instr_i && !interrupt_return_instr_i
      |-> mem_rd_o && mem_addr_o == {10'h001, table_index_field_i[5:1], 1'b0}
      ##1 mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h1;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table fetch wrong");
  c_tbl: cover property (table_call_instr_i && !busy_o);
  c_pop: cover property (status_pop_instr_i && !busy_o);
  c_acc: cover property (irq_accept_o);
endmodule // pcr_core_regs_sva
bind pcr_core_regs pcr_core_regs_sva u_sva (.*);
`default_nettype wire

// file: verilog/pcr_consts.vh
// constants for the program-control register block
// Functional notes
// - instruction pointer is 16 bits, next address
// - sequential execution advances by instruction length
// - branch loads pointer from immediate or register
// - reset loads pointer from bytes 0000H/0001H
// - status word is 8 bits, instruction-driven flags
// - status pushed on interrupt acknowledge and push
// - status popped on break, interrupt return, pop
// - reset sets status word to 02H
// - enable flag 0 blocks all maskable requests
// - enable 1: priority, mask, source priority decide
// - enable cleared by mask-all/acknowledge, set unmask-all
// - zero flag set on zero result, else cleared
// - two bank bits take chosen bank number
// - table call indexes with opcode bits 1-5
// - table lives at 0040H-007FH, any destination
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// register offsets on the software port
`define PCR_OFS_IP_LO 3'h0
`define PCR_OFS_IP_HI 3'h1
`define PCR_OFS_STATUS 3'h2
`define PCR_OFS_STK_LO 3'h3
`define PCR_OFS_STK_HI 3'h4
`define PCR_OFS_STATE 3'h5

// status word field positions and reset value
`define PCR_BIT_INT_EN 7
`define PCR_BIT_Z 6
`define PCR_BIT_BANK_HI 5
`define PCR_BIT_BANK_LO 3
`define PCR_BIT_IN_SVC 1
`define PCR_STATUS_RST 8'h02

// memory locations
`define PCR_RST_VEC_LO 16'h0000
`define PCR_RST_VEC_HI 16'h0001
`define PCR_TABLE_BASE 16'h0040
`define PCR_TABLE_LAST 16'h007F
`define PCR_STK_RST 16'h0000

// number of maskable interrupt sources
`define PCR_NUM_IRQ 8

`endif

// file: verilog/pcr_core_regs.v
// instruction pointer, status word and stack pointer of the core
`timescale 1ns/10ps
`default_nettype none
`include "pcr_consts.vh"

module pcr_core_regs (
  input wire clk_i,
  input wire rst_n_i,
  // software register port
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // sequential advance
  input wire advance_i,
  input wire [2:0] instr_len_i,
  // branches
  input wire branch_i,
  input wire branch_from_reg_i,
  input wire [15:0] branch_imm_i,
  input wire [15:0] branch_reg_i,
  // table call
  input wire table_call_instr_i,
  input wire [5:0] table_index_field_i,
  // status word operations
  input wire status_push_instr_i,
  input wire status_pop_instr_i,
  input wire break_return_instr_i,
  input wire interrupt_return_instr_i,
  input wire mask_all_instr_i,
  input wire unmask_all_instr_i,
  input wire bank_choose_instr_i,
  input wire [1:0] bank_num_i,
  input wire result_valid_i,
  input wire [7:0] result_i,
  // interrupt sources
  input wire [`PCR_NUM_IRQ-1:0] irq_req_i,
  input wire [`PCR_NUM_IRQ-1:0] irq_mask_i,
  input wire [`PCR_NUM_IRQ-1:0] irq_low_prio_i,
  input wire irq_ack_i,
  output wire irq_accept_o,
  output wire [`PCR_NUM_IRQ-1:0] irq_grant_o,
  // memory port, read data arrive one cycle after the read strobe
  output reg [15:0] mem_addr_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output wire [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  // state shown to the core
  output reg [15:0] instruction_pointer_o,
  output wire [7:0] status_word_o,
  output wire [15:0] stack_top_pointer_o,
  output wire [1:0] bank_select_o,
  output wire busy_o
);

  // one-hot sequencer states
  localparam [6:0] ST_BOOT0 = 7'h01;
  localparam [6:0] ST_BOOT1 = 7'h02;
  localparam [6:0] ST_BOOT2 = 7'h04;
  localparam [6:0] ST_IDLE = 7'h08;
  localparam [6:0] ST_TBL1 = 7'h10;
  localparam [6:0] ST_TBL2 = 7'h20;
  localparam [6:0] ST_POP1 = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg [7:0] status_word;
  reg [7:0] next_status;
  reg [15:0] stack_top_pointer;
  reg [15:0] next_stack;
  reg [15:0] next_ip;
  reg [7:0] low_byte;
  reg [7:0] next_low;
  reg [15:0] table_addr;
  reg [15:0] next_table;
  wire idle;
  wire do_push;
  wire do_pop;
  wire [15:0] table_entry;

  assign idle = (state == ST_IDLE);
  assign busy_o = ~idle;
  assign status_word_o = status_word;
  assign stack_top_pointer_o = stack_top_pointer;
  assign bank_select_o = {status_word[`PCR_BIT_BANK_HI], status_word[`PCR_BIT_BANK_LO]};
  assign mem_wdata_o = status_word;

  // push on acknowledge or push instruction; any of three returns pops
  assign do_push = idle & (irq_ack_i | status_push_instr_i);
  assign do_pop = idle & ~do_push &
                  (status_pop_instr_i | break_return_instr_i | interrupt_return_instr_i);

  // entry is two bytes per index, so bits 1..5 land on 0040H..007FH
  assign table_entry = `PCR_TABLE_BASE |
                       {10'h000, table_index_field_i[5:1], 1'b0};

  pcr_irq_gate u_gate (
    .interrupt_enable_flag_i(status_word[`PCR_BIT_INT_EN]),
    .in_service_priority_flag_i(status_word[`PCR_BIT_IN_SVC]),
    .irq_req_i(irq_req_i),
    .irq_mask_i(irq_mask_i),
    .irq_low_prio_i(irq_low_prio_i),
    .irq_grant_o(irq_grant_o),
    .irq_accept_o(irq_accept_o)
  );

  // sequencer and instruction pointer next value
  always @* begin
    next_state = state;
    next_ip = instruction_pointer_o;
    next_low = low_byte;
    next_table = table_addr;
    mem_addr_o = 16'h0000;
    mem_rd_o = 1'b0;
    mem_wr_o = 1'b0;
    case (state)
      ST_BOOT0: begin
        mem_addr_o = `PCR_RST_VEC_LO;
        mem_rd_o = 1'b1;
        next_state = ST_BOOT1;
      end
      ST_BOOT1: begin
        next_low = mem_rdata_i;
        mem_addr_o = `PCR_RST_VEC_HI;
        mem_rd_o = 1'b1;
        next_state = ST_BOOT2;
      end
      ST_BOOT2: begin
        next_ip = {mem_rdata_i, low_byte};
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (do_push) begin
          mem_addr_o = stack_top_pointer - 16'h0001;
          mem_wr_o = 1'b1;
        end else if (do_pop) begin
          mem_addr_o = stack_top_pointer;
          mem_rd_o = 1'b1;
          next_state = ST_POP1;
        end else if (table_call_instr_i) begin
          mem_addr_o = table_entry;
          mem_rd_o = 1'b1;
          next_table = table_entry;
          next_state = ST_TBL1;
        end
        // pointer updates share the idle cycle with a stack access
        if (branch_i) begin
          next_ip = branch_from_reg_i ? branch_reg_i : branch_imm_i;
        end else if (advance_i) begin
          next_ip = instruction_pointer_o + {13'h0000, instr_len_i};
        end
      end
      ST_TBL1: begin
        next_low = mem_rdata_i;
        mem_addr_o = table_addr + 16'h0001;
        mem_rd_o = 1'b1;
        next_state = ST_TBL2;
      end
      ST_TBL2: begin
        next_ip = {mem_rdata_i, low_byte};
        next_state = ST_IDLE;
      end
      ST_POP1: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // status word and stack pointer next values; hardware events over software writes
  always @* begin
    next_status = status_word;
    next_stack = stack_top_pointer;
    if (reg_wr_i && reg_addr_i == `PCR_OFS_STATUS) begin
      next_status = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `PCR_OFS_STK_LO) begin
      next_stack[7:0] = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `PCR_OFS_STK_HI) begin
      next_stack[15:8] = reg_wdata_i;
    end
    if (idle && result_valid_i) begin
      next_status[`PCR_BIT_Z] = (result_i == 8'h00);
    end
    if (idle && bank_choose_instr_i) begin
      next_status[`PCR_BIT_BANK_HI] = bank_num_i[1];
      next_status[`PCR_BIT_BANK_LO] = bank_num_i[0];
    end
    if (idle && unmask_all_instr_i) begin
      next_status[`PCR_BIT_INT_EN] = 1'b1;
    end
    // clearing wins so an acknowledge never leaves interrupts open
    if (idle && (mask_all_instr_i || irq_ack_i)) begin
      next_status[`PCR_BIT_INT_EN] = 1'b0;
    end
    if (do_push) begin
      next_stack = stack_top_pointer - 16'h0001;
    end
    if (state == ST_POP1) begin
      next_status = mem_rdata_i;
      next_stack = stack_top_pointer + 16'h0001;
    end
  end

  // state registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_BOOT0;
      instruction_pointer_o <= 16'h0000;
      status_word <= `PCR_STATUS_RST;
      stack_top_pointer <= `PCR_STK_RST;
      low_byte <= 8'h00;
      table_addr <= 16'h0000;
    end else begin
      state <= next_state;
      instruction_pointer_o <= next_ip;
      status_word <= next_status;
      stack_top_pointer <= next_stack;
      low_byte <= next_low;
      table_addr <= next_table;
    end
  end

  // register read data, valid the cycle after the read strobe
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PCR_OFS_IP_LO: reg_rdata_o <= instruction_pointer_o[7:0];
        `PCR_OFS_IP_HI: reg_rdata_o <= instruction_pointer_o[15:8];
        `PCR_OFS_STATUS: reg_rdata_o <= status_word;
        `PCR_OFS_STK_LO: reg_rdata_o <= stack_top_pointer[7:0];
        `PCR_OFS_STK_HI: reg_rdata_o <= stack_top_pointer[15:8];
        `PCR_OFS_STATE: reg_rdata_o <= {1'b0, state};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // pcr_core_regs

`default_nettype wire

// file: verilog/pcr_irq_gate.v
// maskable interrupt acceptance gate
`timescale 1ns/10ps
`default_nettype none
`include "pcr_consts.vh"

module pcr_irq_gate (
  input wire interrupt_enable_flag_i,
  input wire in_service_priority_flag_i,
  input wire [`PCR_NUM_IRQ-1:0] irq_req_i,
  input wire [`PCR_NUM_IRQ-1:0] irq_mask_i,
  input wire [`PCR_NUM_IRQ-1:0] irq_low_prio_i,
  output wire [`PCR_NUM_IRQ-1:0] irq_grant_o,
  output wire irq_accept_o
);

  wire [`PCR_NUM_IRQ-1:0] eligible;
  genvar g;

  // per source: unmasked, and low priority only when in-service flag allows it
  generate
    for (g = 0; g < `PCR_NUM_IRQ; g = g + 1) begin : g_src
      assign eligible[g] = interrupt_enable_flag_i & irq_req_i[g] & ~irq_mask_i[g] &
                           (~irq_low_prio_i[g] | in_service_priority_flag_i);
    end
  endgenerate

  // lowest index wins, a fixed order keeps the choice deterministic
  assign irq_grant_o = eligible & (~eligible + {{(`PCR_NUM_IRQ-1){1'b0}}, 1'b1});
  assign irq_accept_o = |eligible;

endmodule // pcr_irq_gate

`default_nettype wire
